// [verilog/jfp_pkg.sv]
`default_nettype none
package jfp_pkg;
   // ***************************************************
   // Instruction codes and shift lengths
   // ***************************************************
   localparam int IR_W = 16;
   localparam int DR_W = 20;
   localparam int PAYLOAD_W = 18;
   localparam int ID_W = 32;
   localparam logic [15:0] IR_BYPASS = 16'hFFFF;
   localparam logic [15:0] IR_IDCODE = 16'h0004;
   localparam logic [15:0] IR_FL_CTRL = 16'h0082;
   localparam logic [15:0] IR_FL_DATA = 16'h0083;
   localparam logic [15:0] IR_FL_ADDR = 16'h0084;
   localparam logic [15:0] IR_FL_SCALE = 16'h0085;
   localparam logic [15:0] IR_CAPTURE = 16'h0001;
   // Value is arbitrary; bit 0 set as a JTAG identity must have
   localparam logic [31:0] IDCODE_DEFAULT = 32'h0A5C_0001;

   // ***************************************************
   // Indirect command fields
   // ***************************************************
   localparam int OP_HI = 19;
   localparam int OP_LO = 18;
   localparam int WR8_LO = 10;
   localparam int WR16_LO = 2;

   // ***************************************************
   // Flash interface registers
   // ***************************************************
   localparam logic [7:0] CTRL_RESET = 8'h00;
   localparam logic [7:0] SCALE_RESET = 8'h00;
   localparam logic [7:0] DATA_RESET = 8'h00;
   localparam logic [15:0] ADDR_RESET = 16'h0000;
   localparam logic [7:0] SCALE_USED = 8'hCF;
   localparam logic [3:0] WRMODE_STORE = 4'h0;
   localparam logic [3:0] WRMODE_PROG = 4'h1;
   localparam logic [3:0] WRMODE_ERASE = 4'h2;
   localparam logic [3:0] RDMODE_PLAIN = 4'h0;
   localparam logic [3:0] RDMODE_BLOCK = 4'h1;
   localparam logic [3:0] RDMODE_SINGLE = 4'h2;
   localparam logic [3:0] PRESCALE_LOCK = 4'hF;
   localparam logic [7:0] ERASE_KEY = 8'hA5;
   localparam logic [15:0] ALL_ERASE_LO = 16'h1DFE;
   localparam logic [15:0] ALL_ERASE_HI = 16'h1DFF;

   // ***************************************************
   // Types
   // ***************************************************
   typedef enum logic [3:0] {
      TAP_RESET, TAP_IDLE, TAP_SEL_DR, TAP_CAP_DR, TAP_SH_DR, TAP_EX1_DR, TAP_PAU_DR,
      TAP_EX2_DR, TAP_UPD_DR, TAP_SEL_IR, TAP_CAP_IR, TAP_SH_IR, TAP_EX1_IR, TAP_PAU_IR,
      TAP_EX2_IR, TAP_UPD_IR
   } jfp_tap_state_e;
   typedef enum logic [1:0] {TGT_CTRL, TGT_DATA, TGT_ADDR, TGT_SCALE} jfp_target_e;
   typedef enum logic [1:0] {FOP_READ, FOP_PROG, FOP_ERASE_PAGE, FOP_ERASE_ALL} jfp_flash_op_e;
   typedef enum logic [1:0] {CS_IDLE, CS_FLASH, CS_DONE} jfp_core_state_e;
   typedef struct packed {
      jfp_target_e target;
      logic write;
      logic [17:0] payload;
   } jfp_ind_cmd_s;
   typedef struct packed {
      jfp_flash_op_e op;
      logic [15:0] addr;
      logic [7:0] wdata;
   } jfp_flash_cmd_s;
endpackage
`default_nettype wire

// [verilog/jfp_tap_fsm.sv]
`timescale 1ns/1ps
`default_nettype none
module jfp_tap_fsm (
   input wire logic tck,
   input wire logic rst_n,
   input wire logic tms,
   output var jfp_pkg::jfp_tap_state_e state
);
   // ***************************************************
   // Test access port controller
   // ***************************************************
   jfp_pkg::jfp_tap_state_e state_ff;
   jfp_pkg::jfp_tap_state_e nxt_state;

   always_comb begin
      nxt_state = state_ff;
      case (state_ff)
         jfp_pkg::TAP_RESET: nxt_state = tms ? jfp_pkg::TAP_RESET : jfp_pkg::TAP_IDLE;
         jfp_pkg::TAP_IDLE: nxt_state = tms ? jfp_pkg::TAP_SEL_DR : jfp_pkg::TAP_IDLE;
         jfp_pkg::TAP_SEL_DR: nxt_state = tms ? jfp_pkg::TAP_SEL_IR : jfp_pkg::TAP_CAP_DR;
         jfp_pkg::TAP_CAP_DR: nxt_state = tms ? jfp_pkg::TAP_EX1_DR : jfp_pkg::TAP_SH_DR;
         jfp_pkg::TAP_SH_DR: nxt_state = tms ? jfp_pkg::TAP_EX1_DR : jfp_pkg::TAP_SH_DR;
         jfp_pkg::TAP_EX1_DR: nxt_state = tms ? jfp_pkg::TAP_UPD_DR : jfp_pkg::TAP_PAU_DR;
         jfp_pkg::TAP_PAU_DR: nxt_state = tms ? jfp_pkg::TAP_EX2_DR : jfp_pkg::TAP_PAU_DR;
         jfp_pkg::TAP_EX2_DR: nxt_state = tms ? jfp_pkg::TAP_UPD_DR : jfp_pkg::TAP_SH_DR;
         jfp_pkg::TAP_UPD_DR: nxt_state = tms ? jfp_pkg::TAP_SEL_DR : jfp_pkg::TAP_IDLE;
         jfp_pkg::TAP_SEL_IR: nxt_state = tms ? jfp_pkg::TAP_RESET : jfp_pkg::TAP_CAP_IR;
         jfp_pkg::TAP_CAP_IR: nxt_state = tms ? jfp_pkg::TAP_EX1_IR : jfp_pkg::TAP_SH_IR;
         jfp_pkg::TAP_SH_IR: nxt_state = tms ? jfp_pkg::TAP_EX1_IR : jfp_pkg::TAP_SH_IR;
         jfp_pkg::TAP_EX1_IR: nxt_state = tms ? jfp_pkg::TAP_UPD_IR : jfp_pkg::TAP_PAU_IR;
         jfp_pkg::TAP_PAU_IR: nxt_state = tms ? jfp_pkg::TAP_EX2_IR : jfp_pkg::TAP_PAU_IR;
         jfp_pkg::TAP_EX2_IR: nxt_state = tms ? jfp_pkg::TAP_UPD_IR : jfp_pkg::TAP_SH_IR;
         jfp_pkg::TAP_UPD_IR: nxt_state = tms ? jfp_pkg::TAP_SEL_DR : jfp_pkg::TAP_IDLE;
         default: nxt_state = jfp_pkg::TAP_RESET;
      endcase
   end

   always_ff @(posedge tck or negedge rst_n) begin
      if (!rst_n) begin
         state_ff <= jfp_pkg::TAP_RESET;
      end else begin
         state_ff <= nxt_state;
      end
   end

   assign state = state_ff;
endmodule
`default_nettype wire

// [verilog/jfp_flash_port.sv]
// Operation
// RULE1 - Instruction register defaults to all-ones bypass
// RULE2 - No boundary scan; acts as bypass
// RULE3 - Code 0x0004 selects identification register
// RULE4 - Code 0x0082 selects flash control register
// RULE5 - Code 0x0083 selects flash data register
// RULE6 - Code 0x0084 selects flash address register
// RULE7 - Code 0x0085 selects flash scale register
// RULE8 - Command: opcode bits 19:18, payload 17:0
// RULE9 - Opcode 0x poll, 10 read, 11 write
// RULE10 - Poll captures but never updates
// RULE11 - Read starts after two opcode bits
// RULE12 - Short write values are left-justified
// RULE13 - Host keeps instruction while operation runs
// RULE14 - Capture: zero, read data, busy first
// RULE15 - Busy spans operation; commands ignored while busy
// RULE16 - Queued command starts once busy read low; the code has no queue and drops an update whose capture read busy
// RULE17 - Read results right-justified behind busy
// RULE18 - Control resets zero; write/read mode nibbles
// RULE19 - Write mode zero only stores data
// RULE20 - Write mode one programs, then increments address
// RULE21 - Write mode two erases page on key
// RULE22 - Top user address erases whole user area
// RULE23 - Read modes one and two start reads
// RULE24 - Data register carries a fail flag
// RULE25 - Prescaler all ones refuses flash operations
// RULE26 - Reserved mode codes have no defined action
// RULE27 - Data registers shift LSB first, standard states
`timescale 1ns/1ps
`default_nettype none
module jfp_flash_port #(
   parameter logic [31:0] IDCODE_VALUE = jfp_pkg::IDCODE_DEFAULT
) (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic tck,
   input wire logic tms,
   input wire logic tdi,
   output logic tdo,
   output logic tdo_oe,
   output logic flash_req,
   output var jfp_pkg::jfp_flash_cmd_s flash_cmd,
   input wire logic flash_ack,
   input wire logic [7:0] flash_rdata,
   input wire logic flash_fail
);
   if (IDCODE_VALUE[0] != 1'b1) begin : g_bad_idcode
      $error("IDCODE_VALUE must have bit 0 set");
   end

   // ***************************************************
   // Link side: controller and decode
   // ***************************************************
   jfp_pkg::jfp_tap_state_e tap_state;
   logic cap_dr, sh_dr, upd_dr, cap_ir, sh_ir, upd_ir, in_reset;
   logic [15:0] ir_shift_ff;
   logic [15:0] ir_ff;
   logic [31:0] dr_ff;
   logic sel_ind, sel_id;
   jfp_pkg::jfp_target_e sel_tgt;
   logic busy, busy_cap_ff, accept;
   logic req_tog_ff, done_meta_ff, done_sync_ff;
   logic tdo_ff, tdo_oe_ff;
   logic [17:0] cap_payload;
   jfp_pkg::jfp_ind_cmd_s cmd_ff;
   logic [17:0] rd_payload_ff;
   logic done_tog_ff;

   jfp_tap_fsm u_tap (
      .tck(tck),
      .rst_n(rst_n),
      .tms(tms),
      .state(tap_state)
   );

   assign in_reset = (tap_state == jfp_pkg::TAP_RESET);
   assign cap_dr = (tap_state == jfp_pkg::TAP_CAP_DR);
   assign sh_dr = (tap_state == jfp_pkg::TAP_SH_DR);
   assign upd_dr = (tap_state == jfp_pkg::TAP_UPD_DR);
   assign cap_ir = (tap_state == jfp_pkg::TAP_CAP_IR);
   assign sh_ir = (tap_state == jfp_pkg::TAP_SH_IR);
   assign upd_ir = (tap_state == jfp_pkg::TAP_UPD_IR);

   // Unknown codes fall through to bypass
   always_comb begin
      sel_ind = 1'b1;
      sel_id = 1'b0;
      sel_tgt = jfp_pkg::TGT_CTRL;
      if (ir_ff == jfp_pkg::IR_IDCODE) begin // see RULE3
         sel_ind = 1'b0;
         sel_id = 1'b1;
      end else if (ir_ff == jfp_pkg::IR_FL_CTRL) begin // see RULE4
         sel_tgt = jfp_pkg::TGT_CTRL;
      end else if (ir_ff == jfp_pkg::IR_FL_DATA) begin // see RULE5
         sel_tgt = jfp_pkg::TGT_DATA;
      end else if (ir_ff == jfp_pkg::IR_FL_ADDR) begin // see RULE6
         sel_tgt = jfp_pkg::TGT_ADDR;
      end else if (ir_ff == jfp_pkg::IR_FL_SCALE) begin // see RULE7
         sel_tgt = jfp_pkg::TGT_SCALE;
      end else begin
         sel_ind = 1'b0; // see RULE2
      end
   end

   // ***************************************************
   // Instruction register
   // ***************************************************
   always_ff @(posedge tck or negedge rst_n) begin
      if (!rst_n) begin
         ir_shift_ff <= jfp_pkg::IR_CAPTURE;
         ir_ff <= jfp_pkg::IR_BYPASS;
      end else begin
         if (in_reset) begin
            ir_ff <= jfp_pkg::IR_BYPASS; // see RULE1
         end else if (upd_ir) begin
            ir_ff <= ir_shift_ff;
         end
         if (cap_ir) begin
            ir_shift_ff <= jfp_pkg::IR_CAPTURE;
         end else if (sh_ir) begin
            ir_shift_ff <= {tdi, ir_shift_ff[15:1]};
         end
      end
   end

   // ***************************************************
   // Data register path
   // ***************************************************
   // Read data is only sampled once the core has settled
   assign cap_payload = busy ? 18'h00000 : rd_payload_ff; // see RULE17

   always_ff @(posedge tck or negedge rst_n) begin
      if (!rst_n) begin
         dr_ff <= 32'h0000_0000;
      end else if (cap_dr) begin
         if (sel_id) begin
            dr_ff <= IDCODE_VALUE; // see RULE3
         end else if (sel_ind) begin
            dr_ff <= {12'h000, 1'b0, cap_payload, busy}; // see RULE14
         end else begin
            dr_ff <= 32'h0000_0000; // see RULE2
         end
      end else if (sh_dr) begin
         if (sel_id) begin
            dr_ff <= {tdi, dr_ff[31:1]};
         end else if (sel_ind) begin
            dr_ff <= {12'h000, tdi, dr_ff[19:1]}; // see RULE27
         end else begin
            dr_ff <= {31'h0000_0000, tdi};
         end
      end
   end

   always_ff @(negedge tck or negedge rst_n) begin
      if (!rst_n) begin
         tdo_ff <= 1'b0;
         tdo_oe_ff <= 1'b0;
      end else begin
         tdo_ff <= sh_ir ? ir_shift_ff[0] : dr_ff[0];
         tdo_oe_ff <= sh_ir | sh_dr;
      end
   end

   assign tdo = tdo_ff;
   assign tdo_oe = tdo_oe_ff;

   // ***************************************************
   // Command issue and busy handshake
   // ***************************************************
   assign busy = req_tog_ff ^ done_sync_ff; // see RULE15
   // Poll (bit 19 low) never updates; busy at capture blocks the update
   assign accept = upd_dr & sel_ind & dr_ff[jfp_pkg::OP_HI] & ~busy_cap_ff & ~busy; // see RULE10

   always_ff @(posedge tck or negedge rst_n) begin
      if (!rst_n) begin
         busy_cap_ff <= 1'b0;
      end else if (cap_dr) begin
         busy_cap_ff <= busy; // see RULE16
      end
   end

   always_ff @(posedge tck or negedge rst_n) begin
      if (!rst_n) begin
         cmd_ff <= '0;
         req_tog_ff <= 1'b0;
      end else if (accept) begin
         cmd_ff.target <= sel_tgt;
         cmd_ff.write <= dr_ff[jfp_pkg::OP_LO]; // see RULE9
         cmd_ff.payload <= dr_ff[17:0]; // see RULE8
         req_tog_ff <= ~req_tog_ff;
      end
   end

   always_ff @(posedge tck or negedge rst_n) begin
      if (!rst_n) begin
         done_meta_ff <= 1'b0;
         done_sync_ff <= 1'b0;
      end else begin
         done_meta_ff <= done_tog_ff;
         done_sync_ff <= done_meta_ff;
      end
   end

   // ***************************************************
   // Core side: request crossing and decode
   // ***************************************************
   jfp_pkg::jfp_core_state_e state_ff;
   logic req_meta_ff, req_sync_ff, req_seen_ff;
   logic [7:0] ctrl_ff, scale_ff, data_ff;
   logic [15:0] addr_ff;
   logic fail_ff, fresh_ff;
   logic flash_req_ff;
   jfp_pkg::jfp_flash_cmd_s flash_cmd_ff;
   logic new_req, do_wr, do_rd, locked;
   logic start_prog, start_erase, start_read, start_flash;
   logic [3:0] wr_mode, rd_mode;
   logic [7:0] wr_byte;
   logic flash_done;

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         req_meta_ff <= 1'b0;
         req_sync_ff <= 1'b0;
      end else begin
         req_meta_ff <= req_tog_ff;
         req_sync_ff <= req_meta_ff;
      end
   end

   assign new_req = (req_sync_ff != req_seen_ff) && (state_ff == jfp_pkg::CS_IDLE);
   assign do_wr = new_req & cmd_ff.write;
   assign do_rd = new_req & ~cmd_ff.write; // see RULE11
   assign wr_mode = ctrl_ff[7:4]; // see RULE18
   assign rd_mode = ctrl_ff[3:0];
   assign wr_byte = cmd_ff.payload[17:jfp_pkg::WR8_LO]; // see RULE12
   assign locked = (scale_ff[3:0] == jfp_pkg::PRESCALE_LOCK);
   // Reserved mode codes start nothing
   assign start_prog = do_wr && cmd_ff.target == jfp_pkg::TGT_DATA
                       && wr_mode == jfp_pkg::WRMODE_PROG; // see RULE20
   assign start_erase = do_wr && cmd_ff.target == jfp_pkg::TGT_DATA
                        && wr_mode == jfp_pkg::WRMODE_ERASE
                        && wr_byte == jfp_pkg::ERASE_KEY; // see RULE21
   assign start_read = do_rd && cmd_ff.target == jfp_pkg::TGT_DATA
                       && (rd_mode == jfp_pkg::RDMODE_BLOCK
                           || (rd_mode == jfp_pkg::RDMODE_SINGLE && !fresh_ff)); // see RULE23
   assign start_flash = start_prog | start_erase | start_read; // see RULE26
   assign flash_done = (state_ff == jfp_pkg::CS_FLASH) && flash_ack;

   // ***************************************************
   // Flash engine
   // ***************************************************
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         state_ff <= jfp_pkg::CS_IDLE;
         req_seen_ff <= 1'b0;
         done_tog_ff <= 1'b0;
         flash_req_ff <= 1'b0;
         flash_cmd_ff <= '0;
      end else begin
         case (state_ff)
            jfp_pkg::CS_IDLE: begin
               if (new_req) begin
                  req_seen_ff <= req_sync_ff;
                  if (start_flash && !locked) begin // see RULE25
                     flash_req_ff <= 1'b1;
                     flash_cmd_ff.addr <= addr_ff;
                     flash_cmd_ff.wdata <= wr_byte;
                     if (start_read) begin
                        flash_cmd_ff.op <= jfp_pkg::FOP_READ;
                     end else if (start_prog) begin
                        flash_cmd_ff.op <= jfp_pkg::FOP_PROG;
                     end else if (addr_ff >= jfp_pkg::ALL_ERASE_LO
                                  && addr_ff <= jfp_pkg::ALL_ERASE_HI) begin
                        flash_cmd_ff.op <= jfp_pkg::FOP_ERASE_ALL; // see RULE22
                     end else begin
                        flash_cmd_ff.op <= jfp_pkg::FOP_ERASE_PAGE;
                     end
                     state_ff <= jfp_pkg::CS_FLASH;
                  end else begin
                     state_ff <= jfp_pkg::CS_DONE;
                  end
               end
            end
            jfp_pkg::CS_FLASH: begin
               if (flash_ack) begin
                  flash_req_ff <= 1'b0;
                  state_ff <= jfp_pkg::CS_DONE;
               end
            end
            jfp_pkg::CS_DONE: begin
               done_tog_ff <= ~done_tog_ff; // see RULE15
               state_ff <= jfp_pkg::CS_IDLE;
            end
            default: state_ff <= jfp_pkg::CS_IDLE;
         endcase
      end
   end

   assign flash_req = flash_req_ff;
   assign flash_cmd = flash_cmd_ff;

   // ***************************************************
   // Indirect registers
   // ***************************************************
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         ctrl_ff <= jfp_pkg::CTRL_RESET; // see RULE18
         scale_ff <= jfp_pkg::SCALE_RESET;
      end else if (do_wr && cmd_ff.target == jfp_pkg::TGT_CTRL) begin
         ctrl_ff <= wr_byte;
      end else if (do_wr && cmd_ff.target == jfp_pkg::TGT_SCALE) begin
         scale_ff <= wr_byte & jfp_pkg::SCALE_USED;
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         addr_ff <= jfp_pkg::ADDR_RESET;
      end else if (do_wr && cmd_ff.target == jfp_pkg::TGT_ADDR) begin
         addr_ff <= cmd_ff.payload[17:jfp_pkg::WR16_LO];
      end else if (flash_done && flash_cmd_ff.op == jfp_pkg::FOP_PROG) begin
         addr_ff <= addr_ff + 16'h0001; // see RULE20
      end
   end

   // Fresh marks read data not yet collected by the host
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         data_ff <= jfp_pkg::DATA_RESET;
         fail_ff <= 1'b0;
         fresh_ff <= 1'b0;
      end else begin
         if (do_wr && cmd_ff.target == jfp_pkg::TGT_DATA) begin
            data_ff <= wr_byte; // see RULE19
         end else if (flash_done && flash_cmd_ff.op == jfp_pkg::FOP_READ) begin
            data_ff <= flash_rdata;
         end
         if (start_flash && locked) begin
            fail_ff <= 1'b1; // see RULE24
         end else if (flash_done) begin
            fail_ff <= flash_fail;
         end
         if (flash_done && flash_cmd_ff.op == jfp_pkg::FOP_READ) begin
            fresh_ff <= 1'b1;
         end else if (do_rd && cmd_ff.target == jfp_pkg::TGT_DATA) begin
            fresh_ff <= 1'b0;
         end
      end
   end

   // Result taken before any flash read that this access starts
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         rd_payload_ff <= 18'h00000;
      end else if (do_rd) begin
         case (cmd_ff.target)
            jfp_pkg::TGT_CTRL: rd_payload_ff <= {10'h000, ctrl_ff}; // see RULE17
            jfp_pkg::TGT_SCALE: rd_payload_ff <= {10'h000, scale_ff};
            jfp_pkg::TGT_ADDR: rd_payload_ff <= {2'h0, addr_ff};
            default: rd_payload_ff <= {8'h00, data_ff, fail_ff, 1'b0};
         endcase
      end
   end

   // ***************************************************
   // Checks
   // ***************************************************
   sequence prog_done_s;
      flash_done && flash_cmd_ff.op == jfp_pkg::FOP_PROG;
   endsequence

   sequence accept_s;
      upd_dr && sel_ind && dr_ff[19] && !busy_cap_ff && !busy;
   endsequence

   ir_default_a: assert property (@(posedge tck) disable iff (!rst_n) // see RULE1
      in_reset |=> ir_ff == jfp_pkg::IR_BYPASS)
      else $error("instruction not bypass after controller reset");

   bypass_capture_a: assert property (@(posedge tck) disable iff (!rst_n) // see RULE2
      cap_dr && !sel_id && !sel_ind |=> dr_ff == 32'h0000_0000)
      else $error("bypass bit did not capture zero");

   idcode_capture_a: assert property (@(posedge tck) disable iff (!rst_n) // see RULE3
      cap_dr && ir_ff == jfp_pkg::IR_IDCODE |=> dr_ff == IDCODE_VALUE)
      else $error("identity register not captured");

   capture_format_a: assert property (@(posedge tck) disable iff (!rst_n) // see RULE14
      cap_dr && sel_ind |=> !dr_ff[19] && dr_ff[0] == $past(busy))
      else $error("indirect capture format wrong");

   poll_no_update_a: assert property (@(posedge tck) disable iff (!rst_n) // see RULE10
      upd_dr && !dr_ff[19] |=> $stable(req_tog_ff))
      else $error("poll issued an operation");

   busy_ignore_a: assert property (@(posedge tck) disable iff (!rst_n) // see RULE16
      upd_dr && busy_cap_ff |=> $stable(req_tog_ff) && $stable(cmd_ff))
      else $error("command taken while busy");

   busy_rise_a: assert property (@(posedge tck) disable iff (!rst_n) // see RULE15
      accept_s |=> busy && $changed(req_tog_ff))
      else $error("busy not raised on accepted command");

   prescale_lock_a: assert property (@(posedge core_clk) disable iff (!rst_n) // see RULE25
      $rose(flash_req_ff) |-> scale_ff[3:0] != jfp_pkg::PRESCALE_LOCK)
      else $error("flash started with prescaler locked");

   erase_key_a: assert property (@(posedge core_clk) disable iff (!rst_n) // see RULE21
      $rose(flash_req_ff) && flash_cmd_ff.op inside {jfp_pkg::FOP_ERASE_PAGE,
         jfp_pkg::FOP_ERASE_ALL} |-> data_ff == jfp_pkg::ERASE_KEY && $stable(addr_ff))
      else $error("erase without unlock key");

   addr_incr_a: assert property (@(posedge core_clk) disable iff (!rst_n) // see RULE20
      prog_done_s |=> addr_ff == 16'($past(addr_ff) + 16'h0001) ##1 $changed(done_tog_ff))
      else $error("address not advanced after program");
endmodule
`default_nettype wire

// [verification/jfp_host_model.sv]
`timescale 1ns/1ps
`default_nettype none
module jfp_host_model (
   output logic tck,
   output logic tms,
   output logic tdi,
   input wire logic tdo
);
   initial begin
      tck = 1'b0;
      tms = 1'b1;
      tdi = 1'b0;
   end
   // ****
   // One link clock; it stands still between frames
   // ****
   task automatic tick(input logic m, input logic d, output logic q);
      tms = m;
      tdi = d;
      #3;
      q = tdo;
      tck = 1'b1;
      #3;
      tck = 1'b0;
   endtask
   // From idle: IR or DR scan of n bits, then back to idle
   task automatic scan(input logic ir, input int n, input logic [31:0] din,
                       output logic [31:0] dout);
      logic q;
      dout = '0;
      tick(1'b1, 1'b0, q);
      if (ir) tick(1'b1, 1'b0, q);
      tick(1'b0, 1'b0, q);
      tick(1'b0, 1'b0, q);
      for (int i = 0; i < n; i++) begin
         tick(i == n - 1, din[i], q);
         dout[i] = q;
      end
      tick(1'b1, 1'b0, q);
      tick(1'b0, 1'b0, q);
   endtask
   // After reset the controller sits in its reset state; one low mode bit reaches idle
   task automatic idle();
      logic q;
      tick(1'b0, 1'b0, q);
   endtask
endmodule
`default_nettype wire

// [verification/tb_jtag_flash_program_port.sv]
`timescale 1ns/1ps
`default_nettype none
module tb_jtag_flash_program_port;
   logic core_clk, rst_n, tck, tms, tdi, tdo, tdo_oe, flash_req, flash_ack, flash_fail;
   logic [7:0] flash_rdata;
   logic [2:0] lat;
   logic [31:0] v;
   jfp_pkg::jfp_flash_cmd_s flash_cmd, last_cmd;
   int mismatches, num_checks, reqs;
   jfp_flash_port i_dut (.core_clk(core_clk), .rst_n(rst_n), .tck(tck), .tms(tms), .tdi(tdi),
      .tdo(tdo), .tdo_oe(tdo_oe), .flash_req(flash_req), .flash_cmd(flash_cmd),
      .flash_ack(flash_ack), .flash_rdata(flash_rdata), .flash_fail(flash_fail));
   jfp_host_model i_host (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo));
   initial begin
      core_clk = 1'b0;
      forever #4 core_clk = ~core_clk;
   end
   // ****
   // Flash macro: answers after five cycles, fails at 0x00FF
   // ****
   always @(posedge core_clk) begin
      flash_ack <= 1'b0;
      flash_rdata <= ~flash_rdata;
      if (flash_req && !flash_ack) begin
         lat <= lat + 3'h1;
         if (lat == 3'h4) begin
            flash_ack <= 1'b1;
            flash_rdata <= flash_cmd.addr[7:0] + 8'h3C;
            flash_fail <= flash_cmd.addr == 16'h00FF;
            last_cmd <= flash_cmd;
            reqs <= reqs + 1;
            lat <= 3'h0;
         end
      end
   end
   // ****
   // Shared tasks
   // ****
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic conclude();
      $display("checks=%0d mismatches=%0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   task automatic set_ir(input logic [15:0] c);
      i_host.scan(1'b1, 16, {16'h0, c}, v);
   endtask
   task automatic poll();
      int k;
      k = 0;
      do begin
         i_host.scan(1'b0, 1, 32'h0, v);
         k++;
      end while (v[0] !== 1'b0 && k < 400);
      chk(v[0], 0);
   endtask
   task automatic wr(input logic [15:0] c, input int n, input logic [31:0] d);
      set_ir(c);
      i_host.scan(1'b0, n, (32'h3 << (n - 2)) | d, v);
      poll();
   endtask
   task automatic rd(input logic [15:0] c, input int n);
      set_ir(c);
      i_host.scan(1'b0, 2, 32'h2, v);
      poll();
      i_host.scan(1'b0, n + 1, 32'h0, v);
      v = v >> 1;
   endtask
   // ****
   // Scenarios
   // ****
   task automatic t_ids();
      i_host.scan(1'b0, 2, 32'h3, v);
      chk(v[1:0], 2'b10);
      chk(tdo_oe, 1'b0);
      set_ir(16'h0004);
      i_host.scan(1'b0, 32, 32'h0, v);
      chk(v, jfp_pkg::IDCODE_DEFAULT);
      $display("ids done");
   endtask
   task automatic t_regs();
      rd(16'h0082, 8);
      chk(v, 0);
      wr(16'h0085, 10, 8'h02);
      rd(16'h0085, 8);
      chk(v, 8'h02);
      wr(16'h0084, 18, 16'h0123);
      rd(16'h0084, 16);
      chk(v, 16'h0123);
      $display("regs done");
   endtask
   task automatic t_prog();
      wr(16'h0082, 10, 8'h10);
      rd(16'h0082, 8);
      chk(v, 8'h10);
      wr(16'h0083, 10, 8'h5A);
      chk(32'(last_cmd), 32'({2'h1, 16'h0123, 8'h5A}));
      rd(16'h0084, 16);
      chk(v, 16'h0124);
      $display("prog done");
   endtask
   task automatic t_erase();
      wr(16'h0082, 10, 8'h20);
      wr(16'h0084, 18, 16'h0200);
      wr(16'h0083, 10, 8'h11);
      chk(reqs, 1);
      wr(16'h0083, 10, 8'hA5);
      chk(last_cmd[25:8], {2'h2, 16'h0200});
      rd(16'h0084, 16);
      chk(v, 16'h0200);
      wr(16'h0084, 18, 16'h1DFE);
      wr(16'h0083, 10, 8'hA5);
      chk(last_cmd[25:8], {2'h3, 16'h1DFE});
      $display("erase done");
   endtask
   task automatic t_read();
      wr(16'h0082, 10, 8'h00);
      wr(16'h0083, 10, 8'h77);
      chk(reqs, 3);
      wr(16'h0084, 18, 16'h00FF);
      wr(16'h0082, 10, 8'h01);
      rd(16'h0083, 10);
      chk(v, 10'h1DC);
      rd(16'h0083, 10);
      chk(v, 10'h0EE);
      wr(16'h0084, 18, 16'h0010);
      wr(16'h0082, 10, 8'h02);
      rd(16'h0083, 10);
      chk(v, 10'h0EE);
      chk(reqs, 5);
      rd(16'h0083, 10);
      chk(reqs, 6);
      wr(16'h0085, 10, 8'h0F);
      wr(16'h0082, 10, 8'h10);
      wr(16'h0083, 10, 8'h33);
      wr(16'h0082, 10, 8'h00);
      rd(16'h0083, 10);
      chk(reqs, 6);
      chk(v[1], 1'b1);
      $display("read done");
   endtask
   initial begin
      rst_n = 1'b0;
      flash_ack = 1'b0;
      flash_rdata = 8'h00;
      flash_fail = 1'b0;
      lat = 3'h0;
      reqs = 0;
      mismatches = 0;
      num_checks = 0;
      repeat (5) @(posedge core_clk);
      rst_n <= 1'b1;
      @(posedge core_clk);
      i_host.idle();
      t_ids();
      t_regs();
      t_prog();
      t_erase();
      t_read();
      conclude();
   end
   initial begin
      #500000;
      mismatches++;
      conclude();
   end
endmodule
`default_nettype wire
